// file: arith_accel_unit.sv
// arith_accel_unit: multiply/divide/shift/normalize engine behind six
// byte-wide operand registers and one control/status register.
// assumes a single 50 mhz clock and an avalon-mm master that honours
// waitrequest; the cpu waits the fixed cycle budget before reading.
//
// Functional notes
// - unsigned 16x16 multiply, 32/16 and 16/16 divide, 32-bit shift and normalize
// - no done flag; cpu waits the cycle budget of the operation
// - 32/16 divide gives 32-bit quotient, 16-bit remainder, within 17 cycles
// - 16/16 divide gives 16-bit quotient and remainder within 9 cycles
// - 16x16 multiply gives 32-bit product within 10 cycles
// - normalize 3-20, shift 3-18 cycles, counted from last loading write
// - operands and results in six data bytes; control in one register
// - data write during an operation sets error bit 7; control read clears
// - overflow bit 6 on zero divisor or product above 0x0000ffff
// - direction bit 5: one shifts right, zero shifts left
// - count zero selects normalize; count field then holds shifts done
// - nonzero count shifts the 32-bit operand by that many bits
// - load, execute, read back: three phases per operation
// - byte 0 write restarts the unit; last divisor write starts divide
// - divide: dividend bytes 0-3, divisor 4-5; quotient 0-3, remainder 4-5
// - multiply loads bytes 0,4,1,5; product returns in bytes 0-3
// - normalize of operand with top bit set raises overflow
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ns
module arith_accel_unit
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // register bus
   input wire arith_accel_pkg::av_req_s av_req,
   output arith_accel_pkg::av_rsp_s av_rsp
);
   import arith_accel_pkg::*;

   // ****************************************
   // state
   // ****************************************
   // every register of the unit lives in this one struct; the engines
   // reuse w as working operand and b as divisor or multiplier
   typedef struct packed {
      logic [5:0][7:0] data;
      logic seq_err;
      logic ovf;
      logic dir;
      logic [SC_W-1:0] sc;
      seq_e seq;
      logic wide;
      op_e op;
      logic [4:0] cnt;
      logic [15:0] r;
      logic [31:0] w;
      logic [31:0] a;
      logic [15:0] b;
      logic waitreq;
      logic [31:0] rdata;
   } state_s;

   state_s st;
   state_s next_st;

   // unsigned only: the engines never look at a sign bit
   // one restoring divide step on {remainder, quotient}
   function automatic logic [47:0] div_step(input logic [47:0] x, input logic [15:0] d);
      logic [16:0] t;
      t = {x[47:32], x[31]};
      if (t >= {1'b0, d})
      begin
         div_step = {16'(t - {1'b0, d}), x[30:0], 1'b1};
      end
      else
      begin
         div_step = {t[15:0], x[30:0], 1'b0};
      end
   endfunction

   // ****************************************
   // next-state logic
   // ****************************************
   always_comb
   begin
      logic req;
      logic [7:0] idx;
      logic dsel;
      logic [2:0] n;
      logic err_set;
      logic err_clr;
      logic [47:0] x;
      logic [31:0] p;
      logic [4:0] k;
      logic [4:0] left;
      next_st = st;
      req = (av_req.read | av_req.write) & st.waitreq;
      idx = av_req.address[ADDR_W-1:2];
      dsel = (idx >= IDX_OPERAND_0) && (idx <= IDX_OPERAND_5);
      n = 3'(idx - IDX_OPERAND_0);
      err_set = 1'b0;
      err_clr = 1'b0;
      x = '0;
      p = '0;
      k = '0;
      left = '0;

      // execution engine, two result bits per cycle
      unique case (st.op)
         OP_NONE:
         begin
         end
         OP_DIV:
         begin
            x = div_step(div_step({st.r, st.w}, st.b), st.b);
            next_st.r = x[47:32];
            next_st.w = x[31:0];
            next_st.cnt = st.cnt - 5'd1;
            if (st.cnt == 5'd1)
            begin
               next_st.data[3:0] = x[31:0];
               next_st.data[5:4] = x[47:32];
               next_st.ovf = (st.b == 16'h0000);
               next_st.op = OP_NONE;
            end
         end
         OP_MUL:
         begin
            p = st.w + (st.b[0] ? st.a : 32'h0000_0000)
               + (st.b[1] ? {st.a[30:0], 1'b0} : 32'h0000_0000);
            next_st.w = p;
            next_st.a = {st.a[29:0], 2'b00};
            next_st.b = {2'b00, st.b[15:2]};
            next_st.cnt = st.cnt - 5'd1;
            if (st.cnt == 5'd1)
            begin
               next_st.data[3:0] = p;
               next_st.ovf = (p > MUL_LIMIT);
               next_st.op = OP_NONE;
            end
         end
         OP_SHIFT:
         begin
            // two positions per edge; an odd count ends with a single step
            k = (st.cnt >= 5'd2) ? 5'd2 : 5'd1;
            left = st.cnt - k;
            next_st.w = st.dir ? (st.w >> k) : (st.w << k);
            next_st.cnt = left;
            if (left == 5'd0)
            begin
               next_st.data[3:0] = next_st.w;
               next_st.op = OP_NONE;
            end
         end
         OP_NORM:
         begin
            // stops on a set top bit, or at count 31 so that a zero operand
            // cannot keep the engine busy past its cycle budget
            if (st.w[31] || (st.sc == NORM_MAX_COUNT))
            begin
               next_st.data[3:0] = st.w;
               next_st.ovf = st.w[31] && (st.sc == 5'd0);
               next_st.op = OP_NONE;
            end
            else if (st.w[30] || (st.sc == NORM_ONE_LEFT))
            begin
               next_st.w = {st.w[30:0], 1'b0};
               next_st.sc = st.sc + 5'd1;
            end
            else
            begin
               next_st.w = {st.w[29:0], 2'b00};
               next_st.sc = st.sc + 5'd2;
            end
         end
         default:
         begin
            next_st.op = OP_NONE;
         end
      endcase

      // the request is taken while waitrequest is high, so a held request
      // is never taken twice: the answer cycle blocks req
      // bus handshake: one wait cycle, then a one-cycle answer
      next_st.waitreq = ~req;
      if (req && av_req.read)
      begin
         next_st.rdata = '0;
         if (dsel)
         begin
            next_st.rdata[7:0] = st.data[n];
         end
         else if (idx == IDX_CONTROL)
         begin
            next_st.rdata[7:0] = {st.seq_err, st.ovf, st.dir, st.sc};
            err_clr = 1'b1;
         end
      end

      // register writes and sequence tracking
      if (req && av_req.write && av_req.byteenable[0])
      begin
         if (dsel)
         begin
            next_st.data[n] = av_req.writedata[7:0];
            // a write into a running operation aborts it and flags the misuse
            if (st.op != OP_NONE)
            begin
               err_set = 1'b1;
               next_st.op = OP_NONE;
            end
            // any data write out of the expected order drops the tracker to idle
            next_st.seq = SEQ_IDLE;
            if (n == 3'd0)
            begin
               next_st.seq = SEQ_D0;
               next_st.wide = 1'b0;
            end
            else
            begin
               unique case (st.seq)
                  SEQ_IDLE:
                  begin
                  end
                  SEQ_D0:
                  begin
                     if (n == 3'd4)
                     begin
                        next_st.seq = SEQ_M4;
                     end
                     else if (n == 3'd1)
                     begin
                        next_st.seq = SEQ_D1;
                     end
                  end
                  SEQ_M4:
                  begin
                     if (n == 3'd1)
                     begin
                        next_st.seq = SEQ_M1;
                     end
                  end
                  SEQ_M1:
                  begin
                     if (n == 3'd5)
                     begin
                        next_st.op = OP_MUL;
                        next_st.w = '0;
                        next_st.a = {16'h0000, st.data[1], st.data[0]};
                        next_st.b = {av_req.writedata[7:0], st.data[4]};
                        next_st.cnt = MUL_STEPS;
                        next_st.ovf = 1'b0;
                     end
                  end
                  SEQ_D1:
                  begin
                     if (n == 3'd2)
                     begin
                        next_st.seq = SEQ_D2;
                     end
                     else if (n == 3'd4)
                     begin
                        next_st.seq = SEQ_D4;
                     end
                  end
                  SEQ_D2:
                  begin
                     if (n == 3'd3)
                     begin
                        next_st.seq = SEQ_D3;
                     end
                  end
                  SEQ_D3:
                  begin
                     if (n == 3'd4)
                     begin
                        next_st.seq = SEQ_D4;
                        next_st.wide = 1'b1;
                     end
                  end
                  SEQ_D4:
                  begin
                     if (n == 3'd5)
                     begin
                        next_st.op = OP_DIV;
                        next_st.r = '0;
                        next_st.w = st.wide ? st.data[3:0]
                           : {st.data[1], st.data[0], 16'h0000};
                        next_st.b = {av_req.writedata[7:0], st.data[4]};
                        next_st.cnt = st.wide ? DIV32_STEPS : DIV16_STEPS;
                        next_st.ovf = 1'b0;
                     end
                  end
               endcase
            end
         end
         else if (idx == IDX_CONTROL)
         begin
            next_st.dir = av_req.writedata[BIT_DIR];
            next_st.sc = av_req.writedata[SC_W-1:0];
            // only right after the four operand bytes does a control write start work
            if (st.seq == SEQ_D3)
            begin
               next_st.seq = SEQ_IDLE;
               next_st.w = st.data[3:0];
               next_st.ovf = 1'b0;
               next_st.cnt = av_req.writedata[SC_W-1:0];
               if (av_req.writedata[SC_W-1:0] == 5'd0)
               begin
                  next_st.op = OP_NORM;
               end
               else
               begin
                  next_st.op = OP_SHIFT;
               end
            end
         end
      end

      // error flag: a new error wins over the clearing read
      next_st.seq_err = err_set | (st.seq_err & ~err_clr);
   end

   // ****************************************
   // state register
   // ****************************************
   // reset: all registers zero, waitrequest high so nothing is answered
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st <= '0;
         st.waitreq <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign av_rsp.readdata = st.rdata;
   assign av_rsp.waitrequest = st.waitreq;

endmodule

// file: arith_accel_pkg.sv
// arith_accel_pkg: constants, states and bus carriers for arith_accel_unit.
// assumes an avalon-mm master addressing bytes; one register per word.
package arith_accel_pkg;

   // ****************************************
   // register map (index = byte address / 4)
   // ****************************************
   localparam int ADDR_W = 10;
   localparam logic [7:0] IDX_OPERAND_0 = 8'hf9;
   localparam logic [7:0] IDX_OPERAND_1 = 8'hfa;
   localparam logic [7:0] IDX_OPERAND_2 = 8'hfb;
   localparam logic [7:0] IDX_OPERAND_3 = 8'hfc;
   localparam logic [7:0] IDX_OPERAND_4 = 8'hfd;
   localparam logic [7:0] IDX_OPERAND_5 = 8'hfe;
   localparam logic [7:0] IDX_CONTROL = 8'hff;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // ****************************************
   // control/status fields
   // ****************************************
   localparam int BIT_SEQ_ERR = 7;
   localparam int BIT_OVF = 6;
   localparam int BIT_DIR = 5;
   localparam int SC_W = 5;
   localparam logic [4:0] NORM_MAX_COUNT = 5'h1f;
   localparam logic [4:0] NORM_ONE_LEFT = 5'h1e;
   localparam logic [31:0] MUL_LIMIT = 32'h0000_ffff;

   // ****************************************
   // cycle budgets from the last loading write
   // ****************************************
   localparam int DIV32_CYCLES = 17;
   localparam int DIV16_CYCLES = 9;
   localparam int MUL_CYCLES = 10;
   localparam int NORM_MAX_CYCLES = 20;
   localparam int SHIFT_MAX_CYCLES = 18;
   localparam int BITS_PER_STEP = 2;
   localparam logic [4:0] DIV32_STEPS = 5'(32 / BITS_PER_STEP);
   localparam logic [4:0] DIV16_STEPS = 5'(16 / BITS_PER_STEP);
   localparam logic [4:0] MUL_STEPS = 5'(16 / BITS_PER_STEP);

   // ****************************************
   // states and carriers
   // ****************************************
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b000, SEQ_D0 = 3'b001, SEQ_M4 = 3'b010, SEQ_M1 = 3'b011,
      SEQ_D1 = 3'b100, SEQ_D2 = 3'b101, SEQ_D3 = 3'b110, SEQ_D4 = 3'b111
   } seq_e;

   typedef enum logic [2:0] {
      OP_NONE = 3'b000, OP_DIV = 3'b001, OP_MUL = 3'b010,
      OP_SHIFT = 3'b011, OP_NORM = 3'b100
   } op_e;

   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } av_req_s;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } av_rsp_s;

endpackage

// file: arith_accel_assertions.sv
// arith_accel_assertions: bus handshake and flag checks on the unit ports.
// assumes the one-wait-cycle answer of the register bus.
`timescale 1ns/1ns
module arith_accel_assertions
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // register bus
   input wire arith_accel_pkg::av_req_s av_req,
   input wire arith_accel_pkg::av_rsp_s av_rsp
);
   import arith_accel_pkg::*;
   // ****
   // checks
   // ****
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // request taken at this edge
   wire logic tk = (av_req.read | av_req.write) & av_rsp.waitrequest;
   wire logic rd_ctl = tk & av_req.read & (av_req.address[9:2] == IDX_CONTROL);
   a_answer_next: assert property (tk |=> !av_rsp.waitrequest)
      else $error("no answer after a taken request");
   a_answer_once: assert property (!av_rsp.waitrequest |=> av_rsp.waitrequest)
      else $error("answer longer than one cycle");
   a_no_spurious: assert property (!tk |=> av_rsp.waitrequest)
      else $error("answer without a request");
   a_reset_wait: assert property ($rose(rst_b) |-> av_rsp.waitrequest)
      else $error("answer at first edge after reset");
   a_upper_zero: assert property (!av_rsp.waitrequest |-> av_rsp.readdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_unmapped_zero: assert property (tk && av_req.read &&
      av_req.address[9:2] < IDX_OPERAND_0 |=> av_rsp.readdata == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!(tk && av_req.read) |=> $stable(av_rsp.readdata))
      else $error("read data changed without a read");
   a_err_cleared: assert property (rd_ctl ##[2:3] rd_ctl |=> !av_rsp.readdata[BIT_SEQ_ERR])
      else $error("error flag survived a control read");
   c_ctl_write: cover property (tk && av_req.write && av_req.address[9:2] == IDX_CONTROL);
   c_err_seen: cover property (!av_rsp.waitrequest && av_rsp.readdata[BIT_SEQ_ERR]);
   c_ovf_seen: cover property (!av_rsp.waitrequest && av_rsp.readdata[BIT_OVF]);
endmodule
bind arith_accel_unit arith_accel_assertions i_arith_accel_assertions (.sys_clk(sys_clk),
   .rst_b(rst_b), .av_req(av_req), .av_rsp(av_rsp));

// file: cpu_bus_model.sv
// cpu_bus_model: cpu side of the register bus, one access at a time.
// assumes the unit answers by dropping waitrequest.
`timescale 1ns/1ns
module cpu_bus_model
(
   // clock
   input wire logic sys_clk,
   // register bus
   output arith_accel_pkg::av_req_s av_req,
   input wire arith_accel_pkg::av_rsp_s av_rsp
);
   import arith_accel_pkg::*;
   // ****
   // access tasks
   // ****
   // idle bus, low byte lane only
   initial
   begin
      av_req = '0;
      av_req.byteenable = 4'h1;
   end
   // hold request until waitrequest seen low, then release and idle a cycle
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
      output logic [7:0] q);
      av_req.address <= {idx, 2'b00};
      av_req.read <= !w;
      av_req.write <= w;
      av_req.writedata <= {24'h0, d};
      do
         @(posedge sys_clk);
      while (av_rsp.waitrequest !== 1'b0);
      q = av_rsp.readdata[7:0];
      av_req.read <= 1'b0;
      av_req.write <= 1'b0;
      @(posedge sys_clk);
   endtask
   // no completion flag: idle the cycle budget
   task automatic nop(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
endmodule

// file: arith_accel_unit_tb.sv
// arith_accel_unit_tb: operation sequences through the register bus.
// assumes cpu_bus_model and the checker bound to the unit.
`timescale 1ns/1ns
module arith_accel_unit_tb;
   import arith_accel_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   arith_accel_pkg::av_req_s av_req;
   arith_accel_pkg::av_rsp_s av_rsp;
   int n_mismatch = 0;
   int compares = 0;
   int cyc = 0;
   // edges from a taken write to the next taken access, outside the wait
   localparam int XFER_TAIL = 3;
   // ****
   // harness
   // ****
   always #10 sys_clk = ~sys_clk;
   arith_accel_unit i_arith_accel_unit (.sys_clk(sys_clk), .rst_b(rst_b), .av_req(av_req),
      .av_rsp(av_rsp));
   cpu_bus_model i_cpu_bus_model (.sys_clk(sys_clk), .av_req(av_req), .av_rsp(av_rsp));
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // hang guard
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         end_of_test();
      end
   end
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      i_cpu_bus_model.xfer(1'b1, idx, d, q);
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // read one register, compare under a mask
   task automatic rc(input string nm, input logic [7:0] idx, input logic [7:0] m,
      input logic [7:0] e);
      logic [7:0] q;
      i_cpu_bus_model.xfer(1'b0, idx, 8'h00, q);
      chk(nm, e & m, q & m);
   endtask
   task automatic wrn(input logic [7:0] idx, input int n, input logic [31:0] v);
      for (int i = 0; i < n; i++)
         wr(idx + 8'(i), v[8*i +: 8]);
   endtask
   task automatic rdn(input string nm, input logic [7:0] idx, input int n, input logic [31:0] e);
      for (int i = 0; i < n; i++)
         rc(nm, idx + 8'(i), 8'hff, e[8*i +: 8]);
   endtask
   // ****
   // operations
   // ****
   task automatic do_mul(input logic [15:0] a, input logic [15:0] b);
      logic [31:0] p;
      p = a * b;
      wr(IDX_OPERAND_0, a[7:0]);
      wr(IDX_OPERAND_4, b[7:0]);
      wr(IDX_OPERAND_1, a[15:8]);
      wr(IDX_OPERAND_5, b[15:8]);
      i_cpu_bus_model.nop(MUL_CYCLES - XFER_TAIL);
      rdn("product", IDX_OPERAND_0, 4, p);
      rc("mul flags", IDX_CONTROL, 8'hc0, {1'b0, p > MUL_LIMIT, 6'h0});
   endtask
   task automatic do_div(input logic [31:0] n, input logic [15:0] d, input logic lng);
      logic [31:0] q;
      logic [15:0] r;
      q = (d == 16'h0) ? 32'hffff_ffff : n / d;
      r = (d == 16'h0) ? 16'h0 : 16'(n % d);
      wrn(IDX_OPERAND_0, lng ? 4 : 2, n);
      wrn(IDX_OPERAND_4, 2, {16'h0, d});
      i_cpu_bus_model.nop((lng ? DIV32_CYCLES : DIV16_CYCLES) - XFER_TAIL);
      rdn("quotient", IDX_OPERAND_0, lng ? 4 : 2, q);
      if (d != 16'h0)
         rdn("remainder", IDX_OPERAND_4, 2, {16'h0, r});
      rc("div flags", IDX_CONTROL, 8'hc0, {1'b0, d == 16'h0, 6'h0});
   endtask
   task automatic do_sh(input logic [31:0] v, input logic dir, input logic [4:0] c);
      logic [31:0] e;
      logic [4:0] k;
      e = dir ? v >> c : v << c;
      k = c;
      while (c == 5'h0 && !e[31] && k != 5'h1f)
      begin
         e = e << 1;
         k++;
      end
      wrn(IDX_OPERAND_0, 4, v);
      wr(IDX_CONTROL, {2'b00, dir, c});
      i_cpu_bus_model.nop((c == 5'h0 ? NORM_MAX_CYCLES : SHIFT_MAX_CYCLES) - XFER_TAIL);
      rdn("shifted", IDX_OPERAND_0, 4, e);
      rc("shift ctrl", IDX_CONTROL, 8'hff, {1'b0, c == 5'h0 && v[31], dir, k});
   endtask
   // ****
   // main sequence
   // ****
   initial
   begin
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      for (int i = 0; i < 7; i++)
         rc("reset value", IDX_OPERAND_0 + 8'(i), 8'hff, RESET_BYTE);
      rc("unmapped", 8'h10, 8'hff, 8'h00);
      do_mul(16'h1234, 16'h5678);
      do_mul(16'h00ff, 16'h0002);
      do_div(32'hdead_beef, 16'h1234, 1'b1);
      do_div(32'h0000_f00e, 16'h0007, 1'b0);
      do_div(32'h0001_0000, 16'h0000, 1'b1);
      do_sh(32'h8000_0001, 1'b0, 5'h01);
      do_sh(32'h8000_0001, 1'b1, 5'h1f);
      do_sh(32'h0001_2345, 1'b0, 5'h00);
      do_sh(32'h8000_0000, 1'b0, 5'h00);
      rc("result held", IDX_OPERAND_3, 8'hff, 8'h80);
      // out-of-order load starts nothing, so a byte 0 write is no error
      wr(IDX_OPERAND_0, 8'h11);
      wr(IDX_OPERAND_4, 8'h33);
      wr(IDX_OPERAND_5, 8'h22);
      wr(IDX_OPERAND_0, 8'h11);
      rc("no start", IDX_CONTROL, 8'h80, 8'h00);
      // operand write while a multiply runs
      wr(IDX_OPERAND_4, 8'h33);
      wr(IDX_OPERAND_1, 8'h22);
      wr(IDX_OPERAND_5, 8'h44);
      wr(IDX_OPERAND_0, 8'h55);
      rc("error set", IDX_CONTROL, 8'h80, 8'h80);
      rc("error cleared", IDX_CONTROL, 8'h80, 8'h00);
      wr(IDX_CONTROL, 8'hff);
      rc("ctrl store", IDX_CONTROL, 8'hff, 8'h3f);
      end_of_test();
   end
endmodule
